/* File: rtl/tsf_formatter.sv */
`timescale 1ns/100ps
`default_nettype none
module tsf_formatter
  import tsf_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        FORMAT_LOOP,      // 1 = 72-frame loop format
  input  wire logic        TX_YELLOW,        // yellow alarm to send, high = alarm
  input  wire logic [11:0] TX_LINK_WORD,     // data-mux link bits, bit i in frame i+1
  input  wire logic [10:0] TX_CONC,          // concentrator bits, bit 0 first
  input  wire logic [2:0]  TX_MAINT,         // maintenance bits
  input  wire logic [1:0]  TX_ALARM,         // loop alarm bits
  input  wire logic [3:0]  TX_PROT,          // protection switch bits
  input  wire logic [23:0] SIG_A,            // per-channel A signaling
  input  wire logic [23:0] SIG_B,            // per-channel B signaling
  input  wire logic [7:0]  IN_DATA,          // user byte, channel order
  input  wire logic        IN_VALID,
  output logic             IN_READY,
  output logic             TX_DATA,          // serial line bit
  output logic             TX_STROBE,        // TX_DATA updated
  output logic             TX_SF_START,      // framing bit of frame 1 on TX_DATA
  output logic             TX_UNDERRUN,      // slot filled with idle
  input  wire logic        RX_DATA,          // received line bit, pin
  input  wire logic        RX_STROBE,        // rising edge per received bit, pin
  input  wire logic        RX_SF_SYNC,       // high with frame 1 framing bit, pin
  output logic [11:0]      RX_LINK_WORD,
  output logic             RX_YELLOW,        // far end reported alarm
  output logic [10:0]      RX_CONC,
  output logic [2:0]       RX_MAINT,
  output logic [1:0]       RX_ALARM,
  output logic [3:0]       RX_PROT,
  output logic             RX_SYNC_ERR,      // sync byte pattern wrong
  output logic             RX_UPDATE         // captured values refreshed
);
  // ----------------------------------------------------------------
  // line bit-rate divider
  // ----------------------------------------------------------------
  logic [14:0] acc_q;                        // fractional phase
  logic        bit_en_q;                     // one pulse per line bit
  logic [15:0] acc_sum;                      // phase plus step

  assign acc_sum = {1'b0, acc_q} + {1'b0, RATE_STEP};

  // accumulate, emit a pulse on each overflow
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      acc_q    <= 15'h0000;
      bit_en_q <= 1'b0;
    end else if (acc_sum >= {1'b0, RATE_MOD}) begin
      acc_q    <= 15'(acc_sum - {1'b0, RATE_MOD});
      bit_en_q <= 1'b1;
    end else begin
      acc_q    <= acc_sum[14:0];
      bit_en_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // transmit position
  // ----------------------------------------------------------------
  logic       tx_fpos;                       // framing bit now
  logic [4:0] tx_slot;                       // channel slot
  logic [2:0] tx_bit;                        // bit in slot
  logic [6:0] tx_frame;                      // frame index
  logic       tx_loop_q;                     // format for this superframe

  tsf_frame_pos u_tx_pos (
    .clk      (CLOCK),
    .srst     (SRST),
    .step     (bit_en_q),
    .align    (1'b0),
    .loop_fmt (tx_loop_q),
    .fpos_q   (tx_fpos),
    .slot_q   (tx_slot),
    .bit_q    (tx_bit),
    .frame_q  (tx_frame)
  );

  // ----------------------------------------------------------------
  // superframe holding storage
  // ----------------------------------------------------------------
  logic        sf_tick;                      // framing bit of frame 1
  logic        yel_q;                        // yellow alarm held
  logic [11:0] link_q;                       // data-mux link bits held
  logic [10:0] conc_q;
  logic [2:0]  maint_q;
  logic [1:0]  alarm_q;
  logic [3:0]  prot_q;

  assign sf_tick = bit_en_q && tx_fpos && (tx_frame == 7'h00);

  // sample host values once per superframe
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      tx_loop_q <= 1'b0;
      yel_q     <= 1'b0;
      link_q    <= 12'h000;
      conc_q    <= 11'h000;
      maint_q   <= 3'h0;
      alarm_q   <= 2'h0;
      prot_q    <= 4'h0;
    end else if (sf_tick) begin
      tx_loop_q <= FORMAT_LOOP;
      yel_q     <= TX_YELLOW;
      link_q    <= TX_LINK_WORD;
      conc_q    <= TX_CONC;
      maint_q   <= TX_MAINT;
      alarm_q   <= TX_ALARM;
      prot_q    <= TX_PROT;
    end
  end

  // ----------------------------------------------------------------
  // framing bit selection
  // ----------------------------------------------------------------
  logic [K_COUNT-1:0] loop_fs_v;             // loop even-frame bits by k
  logic [5:0]         tx_k;                  // even frame ordinal
  logic               tx_fbit;               // framing bit for this frame

  // loop even-frame sequence, bit k is frame 2k+2
  assign loop_fs_v = {LP_TAIL_V,
                      LP_SPOIL_LAST,
                      prot_q,
                      alarm_q,
                      maint_q,
                      LP_SPOIL_V,
                      conc_q,
                      LP_HEAD_V};
  assign tx_k = tx_frame[6:1];

  // odd frames terminal pattern, even frames by format
  always_comb begin
    if (!tx_frame[0]) begin
      tx_fbit = ~tx_frame[1];
    end else if (tx_loop_q) begin
      tx_fbit = loop_fs_v[tx_k];
    end else begin
      tx_fbit = STD_FS_V[3'(tx_k)];
    end
  end

  // ----------------------------------------------------------------
  // user data buffer
  // ----------------------------------------------------------------
  logic [7:0] buf_data;                      // head word
  logic       buf_valid;                     // head present
  logic       pop;                           // slot start takes a word
  logic       sync_slot;                     // slot 24 in data-mux format
  logic       sig_frame;                     // robbed-bit frame
  logic       sig_use_b;                     // second signaling frame

  tsf_pair_buffer u_buf (
    .clk       (CLOCK),
    .srst      (SRST),
    .in_data   (IN_DATA),
    .in_valid  (IN_VALID),
    .in_ready  (IN_READY),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (pop)
  );

  assign sync_slot = !tx_loop_q && (tx_slot == SLOT_LAST);
  assign pop       = bit_en_q && !tx_fpos && (tx_bit == 3'h0) && !sync_slot;
  assign sig_frame = (7'(tx_frame % SIG_PERIOD) == SIG_PHASE);
  assign sig_use_b = tx_frame[0] && (7'(tx_frame / SIG_PERIOD) % 7'h02 == 7'h01);

  // ----------------------------------------------------------------
  // channel byte assembly
  // ----------------------------------------------------------------
  logic [7:0] user_byte;                     // head or idle
  logic [7:0] slot_byte;                     // byte for the slot starting
  logic       sig_bit;                       // robbed bit for this channel

  assign user_byte = buf_valid ? buf_data : IDLE_BYTE;
  assign sig_bit   = sig_use_b ? SIG_B[tx_slot] : SIG_A[tx_slot];

  // select sync byte, data-mux byte or loop byte
  always_comb begin
    if (sync_slot) begin
      slot_byte           = SYNC_VALUE;
      slot_byte[YEL_POS]  = ~yel_q;
      slot_byte[LINK_POS] = link_q[4'(tx_frame)];
    end else if (!tx_loop_q) begin
      slot_byte = {user_byte[6:0], NET_BIT8};
    end else if (sig_frame) begin
      slot_byte = {user_byte[7:1], sig_bit};
    end else begin
      slot_byte = user_byte;
    end
  end

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  logic [7:0] byte_q;                        // byte in flight

  // shift out the framing bit, then each slot msb first
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      byte_q      <= 8'h00;
      TX_DATA     <= 1'b0;
      TX_STROBE   <= 1'b0;
      TX_SF_START <= 1'b0;
      TX_UNDERRUN <= 1'b0;
    end else begin
      TX_STROBE   <= bit_en_q;
      TX_SF_START <= sf_tick;
      TX_UNDERRUN <= pop && !buf_valid;
      if (bit_en_q) begin
        if (tx_fpos) begin
          TX_DATA <= tx_fbit;
        end else if (tx_bit == 3'h0) begin
          byte_q  <= slot_byte;
          TX_DATA <= slot_byte[7];
        end else begin
          TX_DATA <= byte_q[3'h7 - tx_bit];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receive pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rx_d_s;                        // data stages
  logic [1:0] rx_st_s;                       // strobe stages
  logic [1:0] rx_sf_s;                       // sync stages
  logic       rx_st_old;                     // strobe delayed past sync
  logic       rx_step;                       // one received bit

  // two flops per pin, edge taken after the second
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rx_d_s    <= 2'h0;
      rx_st_s   <= 2'h0;
      rx_sf_s   <= 2'h0;
      rx_st_old <= 1'b0;
    end else begin
      rx_d_s    <= {rx_d_s[0], RX_DATA};
      rx_st_s   <= {rx_st_s[0], RX_STROBE};
      rx_sf_s   <= {rx_sf_s[0], RX_SF_SYNC};
      rx_st_old <= rx_st_s[1];
    end
  end

  assign rx_step = rx_st_s[1] && !rx_st_old;

  // ----------------------------------------------------------------
  // receive position and capture
  // ----------------------------------------------------------------
  logic               rx_fpos;
  logic [4:0]         rx_slot;
  logic [2:0]         rx_bit;
  logic [6:0]         rx_frame;
  logic               rx_loop_q;             // format for this superframe
  logic               rx_sf;                 // frame 1 framing bit now
  logic [6:0]         rx_sh_q;               // bits of the slot so far
  logic [7:0]         rx_byte;               // slot completed this bit
  logic [K_COUNT-1:0] rx_fs_q;               // even-frame bits by k
  logic [11:0]        rx_link_q;             // link bits collected
  logic               rx_yel_q;              // alarm seen this superframe

  tsf_frame_pos u_rx_pos (
    .clk      (CLOCK),
    .srst     (SRST),
    .step     (rx_step),
    .align    (rx_sf_s[1]),
    .loop_fmt (rx_loop_q),
    .fpos_q   (rx_fpos),
    .slot_q   (rx_slot),
    .bit_q    (rx_bit),
    .frame_q  (rx_frame)
  );

  assign rx_sf   = rx_step && (rx_sf_s[1] || (rx_fpos && rx_frame == 7'h00));
  assign rx_byte = {rx_sh_q, rx_d_s[1]};

  // collect framing bits, sync bytes and link bits
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      rx_sh_q     <= 7'h00;
      rx_fs_q     <= '0;
      rx_link_q   <= 12'h000;
      rx_yel_q    <= 1'b0;
      rx_loop_q   <= 1'b0;
      RX_SYNC_ERR <= 1'b0;
    end else begin
      RX_SYNC_ERR <= 1'b0;
      if (rx_sf) begin
        rx_loop_q <= FORMAT_LOOP;
        rx_yel_q  <= 1'b0;
      end else if (rx_step) begin
        rx_sh_q <= rx_byte[6:0];
        if (rx_fpos && rx_frame[0]) begin
          rx_fs_q[rx_frame[6:1]] <= rx_d_s[1];
        end
        if (!rx_fpos && !rx_loop_q && rx_slot == SLOT_LAST && rx_bit == BIT_LAST) begin
          RX_SYNC_ERR <= (rx_byte & SYNC_MASK) != SYNC_VALUE;
          rx_link_q[4'(rx_frame)] <= rx_byte[LINK_POS];
          if (!rx_byte[YEL_POS]) rx_yel_q <= 1'b1;
        end
      end
    end
  end

  // publish captured values at each superframe start
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      RX_LINK_WORD <= 12'h000;
      RX_YELLOW    <= 1'b0;
      RX_CONC      <= 11'h000;
      RX_MAINT     <= 3'h0;
      RX_ALARM     <= 2'h0;
      RX_PROT      <= 4'h0;
      RX_UPDATE    <= 1'b0;
    end else begin
      RX_UPDATE <= rx_sf;
      if (rx_sf) begin
        RX_LINK_WORD <= rx_link_q;
        RX_YELLOW    <= rx_yel_q;
        RX_CONC      <= rx_fs_q[K_CONC +: 11];
        RX_MAINT     <= rx_fs_q[K_MAINT +: 3];
        RX_ALARM     <= rx_fs_q[K_ALARM +: 2];
        RX_PROT      <= rx_fs_q[K_PROT +: 4];
      end
    end
  end
endmodule // tsf_formatter
`default_nettype wire

/* File: rtl/tsf_pkg.sv */
`default_nettype none
package tsf_pkg;
  // ----------------------------------------------------------------
  // clock and line rate
  // ----------------------------------------------------------------
  localparam int             CLK_PERIOD_NS = 50;                    // 20 mhz system clock
  localparam int             CLK_KHZ       = 1000000 / CLK_PERIOD_NS;
  localparam int             LINE_RATE_KHZ = 1544;                  // line bit rate
  localparam logic [14:0]    RATE_STEP     = 15'(LINE_RATE_KHZ);    // accumulator step
  localparam logic [14:0]    RATE_MOD      = 15'(CLK_KHZ);          // accumulator modulus
  // ----------------------------------------------------------------
  // frame geometry
  // ----------------------------------------------------------------
  localparam logic [4:0]     SLOT_LAST     = 5'h17;                 // slot 24, zero based
  localparam logic [2:0]     BIT_LAST      = 3'h7;                  // last bit in a slot
  localparam logic [6:0]     FRAME_DM_LAST = 7'h0b;                 // 12-frame superframe
  localparam logic [6:0]     FRAME_LP_LAST = 7'h47;                 // 72-frame sequence
  localparam logic [6:0]     SIG_PERIOD    = 7'h06;                 // signaling every 6th
  localparam logic [6:0]     SIG_PHASE     = 7'h05;                 // frame 6 is index 5
  // ----------------------------------------------------------------
  // sync byte, first sent bit at index 7
  // ----------------------------------------------------------------
  localparam logic [7:0]     SYNC_MASK     = 8'hf9;                 // fixed positions
  localparam logic [7:0]     SYNC_VALUE    = 8'hb8;                 // 1,0,1,1,1,x,x,0
  localparam int             YEL_POS       = 2;                     // sync bit 6
  localparam int             LINK_POS      = 1;                     // sync bit 7
  localparam logic           NET_BIT8      = 1'b1;                  // network bit in data mux
  localparam logic [7:0]     IDLE_BYTE     = 8'hff;                 // sent on underrun
  // ----------------------------------------------------------------
  // even-frame framing vectors, bit k is even frame 2k+2
  // ----------------------------------------------------------------
  localparam logic [5:0]     STD_FS_V      = 6'h1c;                 // 0,0,1,1,1,0
  localparam logic [4:0]     LP_HEAD_V     = 5'h1c;                 // frames 2-10
  localparam logic [2:0]     LP_SPOIL_V    = 3'h2;                  // frames 34,36,38
  localparam logic           LP_SPOIL_LAST = 1'b1;                  // frame 58
  localparam logic [6:0]     LP_TAIL_V     = 7'h38;                 // frames 60-72
  localparam int             K_CONC        = 5;                     // first concentrator
  localparam int             K_MAINT       = 19;                    // first maintenance
  localparam int             K_ALARM       = 22;                    // first alarm
  localparam int             K_PROT        = 24;                    // first protection
  localparam int             K_COUNT       = 36;                    // even frames in 72
  // ----------------------------------------------------------------
  // buffer shape
  // ----------------------------------------------------------------
  localparam int             BUF_WIDTH     = 8;
  localparam int             BUF_DEPTH     = 2;
endpackage : tsf_pkg
`default_nettype wire

/* File: rtl/tsf_pair_buffer.sv */
`timescale 1ns/100ps
`default_nettype none
module tsf_pair_buffer
  import tsf_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic [BUF_WIDTH-1:0] in_data,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  output logic [BUF_WIDTH-1:0]      out_data,
  output logic                      out_valid,
  input  wire logic                 out_ready
);
  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [BUF_WIDTH-1:0] mem_q [BUF_DEPTH];   // entries in flip-flops
  logic                 wr_q;                // write index
  logic                 rd_q;                // read index
  logic [1:0]           cnt_q;               // words held
  logic                 push;
  logic                 pop;

  // honest full and empty flags
  assign in_ready  = (cnt_q != 2'(BUF_DEPTH));
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // write side
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop)  rd_q <= ~rd_q;
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
    end
  end
endmodule // tsf_pair_buffer
`default_nettype wire

/* File: rtl/tsf_frame_pos.sv */
`timescale 1ns/100ps
`default_nettype none
module tsf_frame_pos
  import tsf_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       step,       // one line bit passes
  input  wire logic       align,      // this bit is frame 1 framing bit
  input  wire logic       loop_fmt,   // 72-frame sequence
  output logic            fpos_q,     // current bit is the framing bit
  output logic [4:0]      slot_q,     // channel slot 0..23
  output logic [2:0]      bit_q,      // bit within slot, 0 first
  output logic [6:0]      frame_q     // frame index, zero based
);
  logic [6:0] frame_last;             // wrap point for the format

  assign frame_last = loop_fmt ? FRAME_LP_LAST : FRAME_DM_LAST;

  // ----------------------------------------------------------------
  // bit, slot and frame position
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      fpos_q  <= 1'b1;
      slot_q  <= 5'h00;
      bit_q   <= 3'h0;
      frame_q <= 7'h00;
    end else if (step) begin
      if (align || fpos_q) begin
        // framing bit done, first slot next
        fpos_q <= 1'b0;
        slot_q <= 5'h00;
        bit_q  <= 3'h0;
        if (align) frame_q <= 7'h00;
      end else if (bit_q == BIT_LAST) begin
        bit_q <= 3'h0;
        if (slot_q == SLOT_LAST) begin
          // end of frame, wrap superframe
          slot_q  <= 5'h00;
          fpos_q  <= 1'b1;
          frame_q <= (frame_q >= frame_last) ? 7'h00 : frame_q + 7'h01;
        end else begin
          slot_q <= slot_q + 5'h01;
        end
      end else begin
        bit_q <= bit_q + 3'h1;
      end
    end
  end
endmodule // tsf_frame_pos
`default_nettype wire

/* File: sim/tsf_formatter_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module tsf_formatter_properties (
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        IN_READY,
  input wire logic        TX_DATA,
  input wire logic        TX_STROBE,
  input wire logic        TX_SF_START,
  input wire logic        TX_UNDERRUN,
  input wire logic        RX_UPDATE,
  input wire logic [11:0] RX_LINK_WORD
);
  logic [13:0] n_q; // strobes since superframe start
  logic        s_q; // a start was already seen
  // count line bits between superframe starts
  always_ff @(posedge CLOCK) begin
    n_q <= (SRST || TX_SF_START) ? 14'h0 : n_q + 14'(TX_STROBE);
    s_q <= !SRST && (s_q || TX_SF_START);
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  strobe_gap_a: assert property (TX_STROBE |=> !TX_STROBE [*8])
    else $error("strobe gap");
  sf_first_a: assert property (TX_SF_START |-> TX_STROBE && TX_DATA)
    else $error("sf start bit");
  sf_period_a: assert property (TX_SF_START && s_q |-> n_q inside {14'h090b, 14'h3647})
    else $error("sf length");
  data_strobe_a: assert property ($changed(TX_DATA) |-> TX_STROBE)
    else $error("data moved");
  ready_rst_a: assert property ($fell(SRST) |-> IN_READY)
    else $error("not ready");
  reset_quiet_a: assert property (disable iff (1'b0) SRST |=> !TX_STROBE && !RX_UPDATE)
    else $error("active in reset");
  rx_hold_a: assert property (!RX_UPDATE |-> $stable(RX_LINK_WORD))
    else $error("rx word moved");
  update_gap_a: assert property (RX_UPDATE |=> !RX_UPDATE [*8])
    else $error("update gap");
  underrun_slot_a: assert property (TX_UNDERRUN |-> TX_STROBE && TX_DATA)
    else $error("underrun slot");
  sf_c: cover property (TX_SF_START);
  full_c: cover property (!IN_READY);
  upd_c: cover property (RX_UPDATE);
  under_c: cover property (TX_UNDERRUN);
endmodule // tsf_formatter_properties
bind tsf_formatter tsf_formatter_properties i_props (.CLOCK(CLOCK), .SRST(SRST),
  .IN_READY(IN_READY), .TX_DATA(TX_DATA), .TX_STROBE(TX_STROBE), .TX_SF_START(TX_SF_START),
  .TX_UNDERRUN(TX_UNDERRUN), .RX_UPDATE(RX_UPDATE), .RX_LINK_WORD(RX_LINK_WORD));
`default_nettype wire

/* File: sim/tsf_far_end.sv */
`timescale 1ns/100ps
`default_nettype none
module tsf_far_end (
  input  wire logic CLOCK,
  input  wire logic SRST,
  input  wire logic tx_data,
  input  wire logic tx_strobe,
  input  wire logic tx_sf_start,
  input  wire logic corrupt,          // invert echoed bits
  output logic      rx_data = 1'b0,
  output logic      rx_strobe,
  output logic      rx_sf_sync = 1'b0
);
  logic [3:0] dly_q = 4'h0; // cycles since bit taken
  // far terminal loops each line bit back, strobe rises 3 cycles on
  always @(posedge CLOCK) begin
    if (SRST || tx_strobe) dly_q <= {3'h0, tx_strobe};
    else if (dly_q != 4'h0) dly_q <= dly_q + 4'h1;
    if (tx_strobe) rx_data <= tx_data ^ corrupt;
    if (tx_strobe) rx_sf_sync <= tx_sf_start;
  end
  assign rx_strobe = (dly_q[3:2] == 2'b01);
endmodule // tsf_far_end
`default_nettype wire

/* File: sim/tb_tsf_formatter.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_tsf_formatter;
  logic        CLOCK = 1'b0, SRST = 1'b1, FORMAT_LOOP = 1'b0, TX_YELLOW = 1'b0;
  logic        IN_VALID = 1'b0, IN_READY, TX_DATA, TX_STROBE, TX_SF_START, TX_UNDERRUN;
  logic        RX_DATA, RX_STROBE, RX_SF_SYNC, RX_YELLOW, RX_SYNC_ERR, RX_UPDATE, corrupt;
  logic [11:0] TX_LINK_WORD = 12'h0, RX_LINK_WORD;
  logic [10:0] TX_CONC = 11'h0;
  logic [3:0]  TX_PROT = 4'h0;
  logic [2:0]  TX_MAINT = 3'h0;
  logic [1:0]  TX_ALARM = 2'h0;
  logic [23:0] SIG_A = 24'h0, SIG_B = 24'h0;
  logic [7:0]  IN_DATA = 8'h00, cur = 8'h00, q[$];
  int          err_count = 0, total_checks = 0, cyc = 0, f = 0, p = 0, nerr = 0, nb = 0;
  bit          go = 1'b0, m_loop = 1'b0, took = 1'b0, emp = 1'b0, nu = 1'b0;
  assign corrupt = go && !m_loop && f == 2; // spoil frame 3 of the first superframe
  tsf_formatter i_dut (.CLOCK(CLOCK), .SRST(SRST), .FORMAT_LOOP(FORMAT_LOOP),
    .TX_YELLOW(TX_YELLOW), .TX_LINK_WORD(TX_LINK_WORD), .TX_CONC(TX_CONC), .TX_MAINT(TX_MAINT),
    .TX_ALARM(TX_ALARM), .TX_PROT(TX_PROT), .SIG_A(SIG_A), .SIG_B(SIG_B), .IN_DATA(IN_DATA),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .TX_DATA(TX_DATA), .TX_STROBE(TX_STROBE),
    .TX_SF_START(TX_SF_START), .TX_UNDERRUN(TX_UNDERRUN), .RX_DATA(RX_DATA),
    .RX_STROBE(RX_STROBE), .RX_SF_SYNC(RX_SF_SYNC), .RX_LINK_WORD(RX_LINK_WORD),
    .RX_YELLOW(RX_YELLOW), .RX_CONC(), .RX_MAINT(), .RX_ALARM(), .RX_PROT(),
    .RX_SYNC_ERR(RX_SYNC_ERR), .RX_UPDATE(RX_UPDATE));
  tsf_far_end i_far (.CLOCK(CLOCK), .SRST(SRST), .tx_data(TX_DATA), .tx_strobe(TX_STROBE),
    .tx_sf_start(TX_SF_START), .corrupt(corrupt), .rx_data(RX_DATA), .rx_strobe(RX_STROBE),
    .rx_sf_sync(RX_SF_SYNC));
  // expected line bit at frame fr, bit ps of the frame, user byte b
  function automatic logic exp_bit(bit lp, int fr, int ps, logic [7:0] b);
    int          k;
    logic [35:0] fv;
    logic [7:0]  sb;
    logic [5:0]  dv;
    k  = (ps - 1) % 8;
    dv = 6'h1c;
    fv = {7'h38, 1'b1, TX_PROT, TX_ALARM, TX_MAINT, 3'h2, TX_CONC, 5'h1c};
    sb = {5'h17, ~TX_YELLOW, TX_LINK_WORD[fr % 12], 1'b0};
    if (ps == 0) return (fr % 2 == 0) ? ~fr[1] : (lp ? fv[fr / 2] : dv[fr / 2]);
    if (!lp && ps > 184) return sb[7 - k];
    if (!lp) return (k == 7) ? 1'b1 : b[6 - k];
    if (k == 7 && fr % 6 == 5) return (fr % 12 == 5) ? SIG_A[(ps - 1) / 8] : SIG_B[(ps - 1) / 8];
    return b[7 - k];
  endfunction
  task automatic cmp_word(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({11'h0, got}, {11'h0, exp});
  endtask
  task automatic test_done;
    $display("checks=%0d errors=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    forever #25 CLOCK = ~CLOCK;
  end
  // record accepted bytes, cut a hang short
  always @(posedge CLOCK) begin
    cyc++;
    took = !SRST && IN_VALID && IN_READY === 1'b1;
    emp  = (q.size() == 0); // buffer level before this edge
    if (took) q.push_back(IN_DATA);
    if (cyc == 80000) begin
      err_count++;
      test_done;
    end
  end
  // source holds each word until taken, pauses once in loop frame 4
  always @(negedge CLOCK) begin
    if (took) begin
      nb++;
      IN_DATA = (nb % 5 == 0) ? 8'h00 : 8'($urandom);
    end
    if (TX_STROBE === 1'b1) begin
      if (TX_SF_START === 1'b1) begin
        f = 0;
        p = 0;
        m_loop = FORMAT_LOOP;
        go = 1'b1;
      end else if (p == 192) begin
        f++;
        p = 0;
      end else p++;
      nu = go && p % 8 == 1 && (m_loop || p < 185) && emp; // slot start on empty buffer
      if (nu) cur = 8'hff;
      else if (go && p % 8 == 1 && (m_loop || p < 185)) cur = q.pop_front();
      if (go) cmp_bit(TX_DATA, exp_bit(m_loop, f, p, cur));
      if (go) cmp_bit(TX_UNDERRUN, nu);
    end
    if (RX_SYNC_ERR === 1'b1 && go && (f > 0 || m_loop)) nerr++;
    if (RX_UPDATE === 1'b1 && m_loop) begin
      cmp_word(RX_LINK_WORD, TX_LINK_WORD ^ 12'h004);
      cmp_bit(RX_YELLOW, 1'b1);
    end
    // a pending word is never withdrawn; pause the source for ten slots of loop frame 4
    if (took || !IN_VALID) IN_VALID = go && !(m_loop && f == 3 && p > 40 && p < 120);
    if (go && f == 6) FORMAT_LOOP = 1'b1;
  end
  initial begin
    void'($urandom(50707));
    {TX_YELLOW, TX_LINK_WORD, TX_CONC, TX_MAINT, TX_ALARM, TX_PROT} = 33'({$urandom, $urandom});
    SIG_A = 24'($urandom);
    SIG_B = ~SIG_A;
    repeat (16) @(negedge CLOCK);
    SRST = 1'b0;
    while (!(m_loop && f == 12)) @(negedge CLOCK);
    cmp_word(12'(nerr), 12'h001);
    test_done;
  end
endmodule // tb_tsf_formatter
`default_nettype wire
